/* design/psc_params.svh */
`ifndef PSC_PARAMS_SVH
`define PSC_PARAMS_SVH

// Bit index at which the shift window closes
`define PSC_IDX_LAST    3'h7
// Bit index after reset
`define PSC_IDX_RST     3'h0
// Step of the bit index per shifted bit
`define PSC_IDX_STEP    3'h1
// Width of the parallel byte
`define PSC_BYTE_W      8
// Width of the completed-transfer counter
`define PSC_CNT_W       8
// Step of the completed-transfer counter
`define PSC_CNT_STEP    8'h01
// Counter value after reset
`define PSC_CNT_RST     8'h00

`endif

/* design/psc_pkg.sv */
`include "psc_params.svh"

package psc_pkg;

    typedef logic [2:0]                 psc_idx_t;
    typedef logic [`PSC_BYTE_W-1:0]     psc_byte_t;
    typedef logic [`PSC_CNT_W-1:0]      psc_cnt_t;

    // Where the link logic stands in a transfer, as seen by the system side
    typedef enum logic [1:0] {
        PSC_IDLE  = 2'b00,
        PSC_SHIFT = 2'b01,
        PSC_DONE  = 2'b10
    } psc_phase_t;

endpackage : psc_pkg

/* design/psc_sync2.sv */
`timescale 1ns/1ns
`default_nettype none

module psc_sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst_b,
    // Asynchronous input and synchronised copy
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    logic [WIDTH-1:0] nxt_meta;
    logic [WIDTH-1:0] nxt_sync;

    // First stage feeds only the second stage
    always_comb begin
        nxt_meta = i_async;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign o_sync = sync_ff;

endmodule : psc_sync2

`default_nettype wire

/* design/psc_strobe_latch.sv */
`timescale 1ns/1ns
`default_nettype none

module psc_strobe_latch (
    // Link clock and reset
    input  wire logic i_link_clk,
    input  wire logic i_rst_b,
    // Strobe from the parallel port and shift window
    input  wire logic i_write_strobe_n,
    input  wire logic i_shift_window,
    // Captured strobe
    output logic      o_latch
);

    logic latch_ff;
    logic nxt_latch;

    // Held until the window is open and the strobe has gone away
    always_comb begin
        nxt_latch = latch_ff & ~(i_shift_window & i_write_strobe_n);
    end

    // Strobe sets without a clock edge, so a pulse shorter than a period is caught
    always_ff @(posedge i_link_clk or negedge i_rst_b or negedge i_write_strobe_n) begin
        if (!i_rst_b) begin
            latch_ff <= 1'b0;
        end else if (!i_write_strobe_n) begin
            latch_ff <= 1'b1;
        end else begin
            latch_ff <= nxt_latch;
        end
    end

    assign o_latch = latch_ff;

endmodule : psc_strobe_latch

`default_nettype wire

/* design/psc_parallel_to_serial.sv */
`timescale 1ns/1ns
`default_nettype none
`include "psc_params.svh"

module psc_parallel_to_serial (
    // System clock and reset
    input  wire logic                   i_clk,
    input  wire logic                   i_rst_b,
    // Transmit clock of the serial link
    input  wire logic                   i_link_clk,
    // Parallel port side
    input  wire logic                   i_write_strobe_n,
    input  wire logic [`PSC_BYTE_W-1:0] i_parallel_in,
    // Serial link side
    output logic                        o_busy,
    output logic                        o_serial_data_out,
    output logic                        o_serial_clk,
    // System side status
    output logic                        o_busy_sys,
    output logic                        o_done,
    output logic [1:0]                  o_phase,
    output logic [`PSC_CNT_W-1:0]       o_xfer_count
);

    // Picks one bit of the byte at a given index
    function automatic logic psc_pick(
        input psc_pkg::psc_byte_t data,
        input psc_pkg::psc_idx_t  idx
    );
        psc_pick = data[idx];
    endfunction : psc_pick

    // ------------------------------------------------------------
    // Link domain
    // ------------------------------------------------------------

    logic                strobe_latch;
    logic                strobe_sync_ff;
    logic                nxt_strobe_sync;
    logic                busy_ff;
    logic                nxt_busy;
    logic                window_ff;
    logic                nxt_window;
    psc_pkg::psc_idx_t   idx_ff;
    psc_pkg::psc_idx_t   nxt_idx;
    logic                serial_data_out_ff;
    logic                nxt_serial_data_out;
    psc_pkg::psc_byte_t  par_sync;

    psc_strobe_latch u_strobe_latch (
        .i_link_clk       (i_link_clk),
        .i_rst_b          (i_rst_b),
        .i_write_strobe_n (i_write_strobe_n),
        .i_shift_window   (window_ff),
        .o_latch          (strobe_latch)
    );

    // Byte is static for the whole transfer, so a plain two-stage copy is safe
    // Limitation: the copy adds latency, so the byte must settle about one
    // link period before the strobe, or bit zero goes out stale
    psc_sync2 #(
        .WIDTH (`PSC_BYTE_W)
    ) u_par_sync (
        .i_clk   (i_link_clk),
        .i_rst_b (i_rst_b),
        .i_async (i_parallel_in),
        .o_sync  (par_sync)
    );

    // First synchroniser stage of the captured strobe
    always_comb begin
        nxt_strobe_sync = strobe_latch;
    end

    always_ff @(posedge i_link_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            strobe_sync_ff <= 1'b0;
        end else begin
            strobe_sync_ff <= nxt_strobe_sync;
        end
    end

    // Busy is sampled on the falling edge; the high-clock hold term is
    // implicit, since the value cannot change while the clock is high
    always_comb begin
        nxt_busy = (strobe_latch & strobe_sync_ff)
                 | (busy_ff & (strobe_sync_ff | window_ff));
    end

    always_ff @(negedge i_link_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            busy_ff <= 1'b0;
        end else begin
            busy_ff <= nxt_busy;
        end
    end

    // Shift window doubles as second synchroniser stage
    always_comb begin
        nxt_window = busy_ff & (idx_ff != `PSC_IDX_LAST);
    end

    always_ff @(posedge i_link_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            window_ff <= 1'b0;
        end else begin
            window_ff <= nxt_window;
        end
    end

    // Natural 3-bit overflow brings the index back to zero
    always_comb begin
        if (window_ff) begin
            nxt_idx = psc_pkg::psc_idx_t'(idx_ff + `PSC_IDX_STEP);
        end else begin
            nxt_idx = idx_ff;
        end
    end

    always_ff @(posedge i_link_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            idx_ff <= `PSC_IDX_RST;
        end else begin
            idx_ff <= nxt_idx;
        end
    end

    // Registered from the next window and index, so it tracks them exactly
    always_comb begin
        nxt_serial_data_out = nxt_window & psc_pick(par_sync, nxt_idx);
    end

    always_ff @(posedge i_link_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            serial_data_out_ff <= 1'b0;
        end else begin
            serial_data_out_ff <= nxt_serial_data_out;
        end
    end

    assign o_busy            = busy_ff;
    assign o_serial_data_out = serial_data_out_ff;
    // A clock cannot come from a flop without losing its phase; gated here
    assign o_serial_clk      = ~i_link_clk & window_ff;

    // ------------------------------------------------------------
    // System domain
    // ------------------------------------------------------------

    logic                 busy_sys;
    logic                 busy_sys_d_ff;
    logic                 nxt_busy_sys_d;
    logic                 done_ff;
    logic                 nxt_done;
    psc_pkg::psc_phase_t  phase_ff;
    psc_pkg::psc_phase_t  nxt_phase;
    psc_pkg::psc_cnt_t    cnt_ff;
    psc_pkg::psc_cnt_t    nxt_cnt;

    psc_sync2 #(
        .WIDTH (1)
    ) u_busy_sync (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_async (busy_ff),
        .o_sync  (busy_sys)
    );

    // Falling busy marks one finished byte
    always_comb begin
        nxt_busy_sys_d = busy_sys;
        nxt_done       = busy_sys_d_ff & ~busy_sys;
        if (nxt_done) begin
            nxt_cnt = psc_pkg::psc_cnt_t'(cnt_ff + `PSC_CNT_STEP);
        end else begin
            nxt_cnt = cnt_ff;
        end
    end

    always_comb begin
        case (phase_ff)
            psc_pkg::PSC_IDLE: begin
                nxt_phase = busy_sys ? psc_pkg::PSC_SHIFT : psc_pkg::PSC_IDLE;
            end
            psc_pkg::PSC_SHIFT: begin
                nxt_phase = busy_sys ? psc_pkg::PSC_SHIFT : psc_pkg::PSC_DONE;
            end
            psc_pkg::PSC_DONE: begin
                nxt_phase = busy_sys ? psc_pkg::PSC_SHIFT : psc_pkg::PSC_IDLE;
            end
            default: begin
                nxt_phase = psc_pkg::PSC_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            busy_sys_d_ff <= 1'b0;
            done_ff       <= 1'b0;
            phase_ff      <= psc_pkg::PSC_IDLE;
            cnt_ff        <= `PSC_CNT_RST;
        end else begin
            busy_sys_d_ff <= nxt_busy_sys_d;
            done_ff       <= nxt_done;
            phase_ff      <= nxt_phase;
            cnt_ff        <= nxt_cnt;
        end
    end

    assign o_busy_sys   = busy_sys;
    assign o_done       = done_ff;
    assign o_phase      = phase_ff;
    assign o_xfer_count = cnt_ff;

endmodule : psc_parallel_to_serial

`default_nettype wire

/* testbench/psc_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
`include "psc_params.svh"

module psc_asserts (
    // Clocks and reset
    input wire logic                  i_clk,
    input wire logic                  i_rst_b,
    input wire logic                  i_link_clk,
    // Watched outputs
    input wire logic                  o_busy,
    input wire logic                  o_serial_data_out,
    input wire logic                  o_serial_clk,
    input wire logic                  o_busy_sys,
    input wire logic                  o_done,
    input wire logic [`PSC_CNT_W-1:0] o_xfer_count
);
    // Rising link edge: sampled gated clock equals the window of the low half before
    sequence win_s;
        o_serial_clk [*8] ##1 !o_serial_clk;
    endsequence
    sequence done_s;
        o_done ##1 !o_done;
    endsequence
    win_len_a: assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
        $rose(o_serial_clk) |-> win_s) else $error("window not eight bits");
    win_start_a: assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
        $rose(o_busy) |=> $rose(o_serial_clk)) else $error("window late");
    busy_hold_a: assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
        o_serial_clk |-> o_busy) else $error("busy low in window");
    busy_end_a: assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
        $fell(o_serial_clk) |-> $fell(o_busy)) else $error("busy not dropped");
    data_idle_a: assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
        !o_serial_clk |-> !o_serial_data_out) else $error("data outside window");
    sys_follow_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        $rose(o_busy) |-> ##[1:3] o_busy_sys) else $error("busy_sys late");
    done_pulse_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        $fell(o_busy_sys) |=> done_s) else $error("done pulse wrong");
    count_step_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        o_done |-> o_xfer_count == $past(o_xfer_count) + `PSC_CNT_STEP)
        else $error("count step wrong");
endmodule : psc_asserts

bind psc_parallel_to_serial psc_asserts psc_asserts_i (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_link_clk(i_link_clk), .o_busy(o_busy), .o_serial_data_out(o_serial_data_out),
    .o_serial_clk(o_serial_clk), .o_busy_sys(o_busy_sys), .o_done(o_done),
    .o_xfer_count(o_xfer_count));
`default_nettype wire

/* testbench/psc_rx_model.sv */
`timescale 1ns/1ns
`default_nettype none

module psc_rx_model (
    // Serial link
    input  wire logic       i_sclk,
    input  wire logic       i_sdata,
    // Received byte and bit tally
    output logic      [7:0] o_byte,
    output logic      [3:0] o_bits
);
    initial begin
        o_byte = 8'h00;
        o_bits = 4'h0;
    end
    // Rising gated edge is mid-bit; LSB arrives first
    always @(posedge i_sclk) begin
        o_byte <= {i_sdata, o_byte[7:1]};
        o_bits <= o_bits + 4'h1;
    end
endmodule : psc_rx_model
`default_nettype wire

/* testbench/test_parallel_to_serial_converter.sv */
`timescale 1ns/1ns
`default_nettype none

module test_parallel_to_serial_converter;
    logic       i_clk = 1'b0;
    logic       i_rst_b = 1'b0;
    logic       lclk = 1'b0;
    logic       strb_n = 1'b1;
    logic [7:0] pin = 8'h00;
    logic       busy, serial_data_out, sclk, bsys, done;
    logic [7:0] cnt, rx_byte;
    logic [1:0] phase;
    logic [7:0] exp_cnt = 8'h00;
    logic [3:0] rx_bits;
    int         fail_count = 0;
    int         total_checks = 0;

    always #10 i_clk = ~i_clk;
    // Offset keeps link clock unrelated in phase
    initial #7 forever #15 lclk = ~lclk;

    psc_parallel_to_serial psc_parallel_to_serial_i (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_link_clk(lclk), .i_write_strobe_n(strb_n), .i_parallel_in(pin), .o_busy(busy),
        .o_serial_data_out(serial_data_out), .o_serial_clk(sclk), .o_busy_sys(bsys), .o_done(done),
        .o_phase(phase), .o_xfer_count(cnt));
    psc_rx_model psc_rx_model_i (.i_sclk(sclk), .i_sdata(serial_data_out), .o_byte(rx_byte),
        .o_bits(rx_bits));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim();
        if (fail_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim

    task automatic wait_out(input logic sel, input logic lvl);
        int n = 0;
        while ((sel ? done : busy) !== lvl && n < 100) begin
            @(negedge i_clk);
            n++;
        end
        check({7'h0, sel ? done : busy}, {7'h0, lvl});
    endtask : wait_out

    task automatic send(input logic [7:0] b);
        logic [3:0] bits0;
        bits0 = rx_bits;
        @(posedge i_clk);
        pin <= b;
        // Byte settles through the link-side copy before the strobe
        repeat (4) @(posedge i_clk);
        strb_n <= 1'b0;
        @(posedge i_clk);
        strb_n <= 1'b1;
        wait_out(1'b0, 1'b1);
        wait_out(1'b0, 1'b0);
        check({6'h0, phase}, 8'h01);
        wait_out(1'b1, 1'b1);
        check({6'h0, phase}, 8'h02);
        exp_cnt = exp_cnt + 8'h01;
        check(rx_byte, b);
        check({4'h0, rx_bits - bits0}, 8'h08);
        check(cnt, exp_cnt);
    endtask : send

    task automatic sc_reset();
        check({4'h0, busy, serial_data_out, sclk, bsys}, 8'h00);
        check(cnt, 8'h00);
        check({6'h0, phase}, 8'h00);
    endtask : sc_reset

    // Back to back; later bytes start at bit zero only if the index wrapped
    task automatic sc_wrap();
        send(8'h01);
        send(8'h80);
        send(8'ha5);
    endtask : sc_wrap

    task automatic sc_mid_reset();
        @(posedge i_clk);
        pin <= 8'h5a;
        repeat (4) @(posedge i_clk);
        strb_n <= 1'b0;
        @(posedge i_clk);
        strb_n <= 1'b1;
        repeat (8) @(posedge i_clk);
        i_rst_b <= 1'b0;
        repeat (3) @(posedge i_clk);
        sc_reset();
        i_rst_b <= 1'b1;
        exp_cnt = 8'h00;
        repeat (3) @(posedge lclk);
        send(8'h3c);
    endtask : sc_mid_reset

    initial begin
        repeat (2) @(posedge i_clk);
        sc_reset();
        i_rst_b <= 1'b1;
        repeat (3) @(posedge lclk);
        sc_wrap();
        sc_mid_reset();
        end_sim();
    end

    initial begin
        #100000;
        fail_count++;
        end_sim();
    end
endmodule : test_parallel_to_serial_converter
`default_nettype wire
